// *** logic/dcc_defs.svh ***
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// Register byte addresses on the plain register port.
`define DCC_ADDR_FLAGS      8'h0D
`define DCC_ADDR_ENABLES    8'h8D
`define DCC_ADDR_CONTROL    8'h9C
`define DCC_ADDR_LADDER     8'h9D
`define DCC_ADDR_CORE       8'h0B

// Reset values.
`define DCC_RST_CONTROL     8'h07
`define DCC_RST_LADDER      8'h00
`define DCC_RST_FLAGS       8'h00
`define DCC_RST_ENABLES     8'h00
`define DCC_RST_CORE        8'h00

// Bit positions in the comparator control register.
`define DCC_BIT_SECOND_RES  7
`define DCC_BIT_FIRST_RES   6
`define DCC_BIT_SECOND_INV  5
`define DCC_BIT_FIRST_INV   4
`define DCC_BIT_INPUT_SW    3

// Bit positions in the flag, enable, core and ladder registers.
`define DCC_BIT_CHANGE      6
`define DCC_BIT_GLOBAL_EN   7
`define DCC_BIT_PERIPH_EN   6
`define DCC_BIT_LAD_POWER   7
`define DCC_BIT_LAD_PIN     6
`define DCC_BIT_LAD_RANGE   5

// Writable masks; unimplemented bits read as zero.
`define DCC_MASK_CONTROL_W  8'h3F
`define DCC_MASK_LADDER     8'hEF
`define DCC_MASK_FLAGS      8'hEB
`define DCC_MASK_ENABLES    8'hEB

// Settling time after a mode change, in ns, and its cycle count at 10 ns.
`define DCC_SETTLE_NS       10000
`define DCC_CLK_NS          10
`define DCC_SETTLE_CYC      ((`DCC_SETTLE_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)
`define DCC_CNT_W           11

`endif

// *** logic/dcc_pkg.sv ***
package dcc_pkg;

    // Comparator operating modes held in the 3-bit mode field.
    typedef enum logic [2:0] {
        DCC_MODE_RESET_ANALOG = 3'h0,
        DCC_MODE_ONE_INDEP    = 3'h1,
        DCC_MODE_TWO_INDEP    = 3'h2,
        DCC_MODE_TWO_COMMON   = 3'h3,
        DCC_MODE_COMMON_OUT   = 3'h4,
        DCC_MODE_ONE_ONLY     = 3'h5,
        DCC_MODE_SWITCHED_REF = 3'h6,
        DCC_MODE_OFF          = 3'h7
    } dcc_mode_e;

endpackage

// *** logic/dcc_sync2.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for one asynchronous level.
module dcc_sync2 (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** logic/dcc_top.sv ***
`timescale 1ns/1ps
`include "dcc_defs.svh"
module dcc_top (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       first_raw,
    input  wire logic       second_raw,
    input  wire logic [1:0] port_a_direction,
    output logic            irq_req,
    output logic            wake_req,
    output logic            results_valid,
    output logic      [2:0] comparator_mode_field,
    output logic            input_switch,
    output logic            ladder_power_enable,
    output logic            ladder_range_select,
    output logic            ladder_pin_output_enable,
    output logic      [3:0] ladder_tap_select,
    output logic            ref_on_plus_inputs,
    output logic            first_active,
    output logic            second_active,
    output logic            route_to_pins,
    output logic            first_invert,
    output logic            second_invert,
    output logic      [1:0] pin_drive_oe
);
    logic [5:0]            ctrl_q;
    logic [7:0]            ladder_q;
    logic [7:0]            flags_q;
    logic [7:0]            enables_q;
    logic [7:0]            core_q;
    logic [1:0]            raw_gated;
    logic [1:0]            res_sync;
    logic [1:0]            res_view;
    logic [1:0]            ref_q;
    logic [`DCC_CNT_W-1:0] settle_q;
    logic                  ctrl_access;
    logic                  mismatch;
    logic                  flag_wr;
    logic                  flag_set;
    dcc_pkg::dcc_mode_e    mode;

    assign mode = dcc_pkg::dcc_mode_e'(ctrl_q[2:0]);

    // Off mode and unused comparators hold their raw result low.
    always_comb begin
        raw_gated = {second_raw, first_raw};
        unique case (mode)
            dcc_pkg::DCC_MODE_OFF:          raw_gated = 2'h0;
            dcc_pkg::DCC_MODE_RESET_ANALOG: raw_gated = 2'h0;
            dcc_pkg::DCC_MODE_ONE_ONLY:     raw_gated[1] = 1'b0;
            dcc_pkg::DCC_MODE_ONE_INDEP,
            dcc_pkg::DCC_MODE_TWO_INDEP,
            dcc_pkg::DCC_MODE_TWO_COMMON,
            dcc_pkg::DCC_MODE_COMMON_OUT,
            dcc_pkg::DCC_MODE_SWITCHED_REF: raw_gated = {second_raw, first_raw};
        endcase
    end

    // Each result is synchronised before any clocked logic reads it.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            dcc_sync2 u_sync (
                .clock    (clock),
                .rst_n    (rst_n),
                .clk_en   (clk_en),
                .async_in (raw_gated[gi]),
                .sync_out (res_sync[gi])
            );
        end
    endgenerate

    // Inversion applies to the reported result.
    assign res_view = res_sync ^ {ctrl_q[`DCC_BIT_SECOND_INV], ctrl_q[`DCC_BIT_FIRST_INV]};

    assign ctrl_access = (reg_wr || reg_rd) && (reg_addr == `DCC_ADDR_CONTROL);
    assign mismatch    = (res_view != ref_q);
    assign flag_wr     = reg_wr && (reg_addr == `DCC_ADDR_FLAGS);
    assign flag_set    = mismatch;

    // Control register: writable low six bits, results are not stored here.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 6'(`DCC_RST_CONTROL);
        end else if (clk_en && reg_wr && reg_addr == `DCC_ADDR_CONTROL) begin
            ctrl_q <= reg_wdata[5:0];
        end
    end

    // Ladder control, with the unimplemented bit held at zero.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ladder_q <= `DCC_RST_LADDER;
        end else if (clk_en && reg_wr && reg_addr == `DCC_ADDR_LADDER) begin
            ladder_q <= reg_wdata & `DCC_MASK_LADDER;
        end
    end

    // Enable registers for the peripheral and core interrupt paths.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enables_q <= `DCC_RST_ENABLES;
            core_q    <= `DCC_RST_CORE;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `DCC_ADDR_ENABLES) begin
                enables_q <= reg_wdata & `DCC_MASK_ENABLES;
            end
            if (reg_addr == `DCC_ADDR_CORE) begin
                core_q <= reg_wdata;
            end
        end
    end

    // Flag register; a hardware set wins over a software clear.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= `DCC_RST_FLAGS;
        end else if (clk_en) begin
            if (flag_wr) begin
                flags_q <= reg_wdata & `DCC_MASK_FLAGS;
            end
            if (flag_set) begin
                flags_q[`DCC_BIT_CHANGE] <= 1'b1;
            end
        end
    end

    // Reference for change detection, reloaded on each control access.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= 2'h0;
        end else if (clk_en && ctrl_access) begin
            ref_q <= res_view;
        end
    end

    // Settling counter restarts on every write that changes the mode.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            settle_q <= '0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `DCC_ADDR_CONTROL && reg_wdata[2:0] != ctrl_q[2:0]) begin
                settle_q <= `DCC_CNT_W'(`DCC_SETTLE_CYC);
            end else if (settle_q != '0) begin
                settle_q <= settle_q - `DCC_CNT_W'(1);
            end
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    `DCC_ADDR_CONTROL: reg_rdata <= {res_view, ctrl_q};
                    `DCC_ADDR_LADDER:  reg_rdata <= ladder_q;
                    `DCC_ADDR_FLAGS:   reg_rdata <= flags_q;
                    `DCC_ADDR_ENABLES: reg_rdata <= enables_q;
                    `DCC_ADDR_CORE:    reg_rdata <= core_q;
                    default:           reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Registered status and steering outputs for the analog side.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_req                  <= 1'b0;
            wake_req                 <= 1'b0;
            results_valid            <= 1'b0;
            comparator_mode_field    <= 3'h7;
            input_switch             <= 1'b0;
            ladder_power_enable      <= 1'b0;
            ladder_range_select      <= 1'b0;
            ladder_pin_output_enable <= 1'b0;
            ladder_tap_select        <= 4'h0;
            ref_on_plus_inputs       <= 1'b0;
            first_active             <= 1'b0;
            second_active            <= 1'b0;
            route_to_pins            <= 1'b0;
            first_invert             <= 1'b0;
            second_invert            <= 1'b0;
            pin_drive_oe             <= 2'h0;
        end else if (clk_en) begin
            irq_req <= flags_q[`DCC_BIT_CHANGE] && enables_q[`DCC_BIT_CHANGE]
                       && core_q[`DCC_BIT_PERIPH_EN] && core_q[`DCC_BIT_GLOBAL_EN];
            wake_req <= flags_q[`DCC_BIT_CHANGE] && enables_q[`DCC_BIT_CHANGE];
            results_valid            <= (settle_q == '0) && (mode != dcc_pkg::DCC_MODE_OFF);
            comparator_mode_field    <= ctrl_q[2:0];
            input_switch             <= ctrl_q[`DCC_BIT_INPUT_SW];
            ladder_power_enable      <= ladder_q[`DCC_BIT_LAD_POWER];
            ladder_range_select      <= ladder_q[`DCC_BIT_LAD_RANGE];
            ladder_pin_output_enable <= ladder_q[`DCC_BIT_LAD_PIN];
            ladder_tap_select        <= ladder_q[3:0];
            ref_on_plus_inputs       <= (mode == dcc_pkg::DCC_MODE_SWITCHED_REF);
            first_active  <= (mode != dcc_pkg::DCC_MODE_OFF)
                             && (mode != dcc_pkg::DCC_MODE_RESET_ANALOG);
            second_active <= (mode != dcc_pkg::DCC_MODE_OFF)
                             && (mode != dcc_pkg::DCC_MODE_RESET_ANALOG)
                             && (mode != dcc_pkg::DCC_MODE_ONE_ONLY);
            route_to_pins <= (mode == dcc_pkg::DCC_MODE_COMMON_OUT)
                             || (mode == dcc_pkg::DCC_MODE_ONE_INDEP);
            first_invert  <= ctrl_q[`DCC_BIT_FIRST_INV];
            second_invert <= ctrl_q[`DCC_BIT_SECOND_INV];
            // Direction bits low mean output, so they gate the routed drivers.
            pin_drive_oe  <= ~port_a_direction & {2{(mode == dcc_pkg::DCC_MODE_COMMON_OUT)
                             || (mode == dcc_pkg::DCC_MODE_ONE_INDEP)}};
        end
    end
endmodule

// *** sim/dcc_monitor.sv ***
`timescale 1ns/1ps
// Watches the register port and control outputs of the comparator block.
module dcc_monitor (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] port_a_direction,
    input wire logic       irq_req,
    input wire logic       wake_req,
    input wire logic       results_valid,
    input wire logic [2:0] comparator_mode_field,
    input wire logic       ladder_power_enable,
    input wire logic       ladder_range_select,
    input wire logic       ladder_pin_output_enable,
    input wire logic [3:0] ladder_tap_select,
    input wire logic       ref_on_plus_inputs,
    input wire logic       first_invert,
    input wire logic       second_invert,
    input wire logic [1:0] pin_drive_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Writes taken on an enabled edge, and a held off mode.
    sequence ctrl_wr_s; clk_en && reg_wr && reg_addr == 8'h9C; endsequence
    sequence lad_wr_s; clk_en && reg_wr && reg_addr == 8'h9D; endsequence
    sequence off_held_s; comparator_mode_field == 3'h7 [*2]; endsequence

    // The register is taken at the strobe edge and copied to its output one edge later.
    mode_write_a:
        assert property (ctrl_wr_s |-> ##2
            {5'h00, comparator_mode_field} == ($past(reg_wdata, 2) & 8'h07))
        else $error("mode field copy wrong");
    invert_write_a:
        assert property (ctrl_wr_s |-> ##2
            {2'b00, second_invert, first_invert, 4'h0} == ($past(reg_wdata, 2) & 8'h30))
        else $error("invert copy wrong");
    ladder_write_a:
        assert property (lad_wr_s |-> ##2 {ladder_power_enable, ladder_pin_output_enable,
            ladder_range_select, 1'b0, ladder_tap_select} == ($past(reg_wdata, 2) & 8'hEF))
        else $error("ladder copy wrong");
    ref_mode_a:
        assert property (comparator_mode_field == 3'h6 |-> ##[0:1] ref_on_plus_inputs)
        else $error("reference not on plus inputs");
    off_mode_a:
        assert property (off_held_s |-> !results_valid)
        else $error("results valid in off mode");
    settle_low_a:
        assert property ($changed(comparator_mode_field) |-> ##[0:1] !results_valid)
        else $error("no settling after mode change");
    irq_gate_a:
        assert property (irq_req |-> wake_req)
        else $error("request without change enable");
    pin_gate_a:
        assert property (pin_drive_oe != 2'b00 |-> (pin_drive_oe & $past(port_a_direction)) == 2'b00)
        else $error("pin driven while input");
    reset_mode_a:
        assert property ($rose(rst_n) |-> comparator_mode_field == 3'h7 && reg_rdata == 8'h00)
        else $error("reset state wrong");
endmodule

bind dcc_top dcc_monitor dcc_monitor_inst (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .port_a_direction(port_a_direction),
    .irq_req(irq_req), .wake_req(wake_req), .results_valid(results_valid),
    .comparator_mode_field(comparator_mode_field), .ladder_power_enable(ladder_power_enable),
    .ladder_range_select(ladder_range_select), .ladder_pin_output_enable(ladder_pin_output_enable),
    .ladder_tap_select(ladder_tap_select), .ref_on_plus_inputs(ref_on_plus_inputs),
    .first_invert(first_invert), .second_invert(second_invert), .pin_drive_oe(pin_drive_oe));

// *** sim/dcc_analog_src.sv ***
`timescale 1ns/1ps
// Analog front end: each output follows its requested level after a response delay.
module dcc_analog_src (
    input  wire logic       slow,
    input  wire logic [1:0] want,
    output logic            first_raw,
    output logic            second_raw
);
    // Slow mode mimics a long comparator response, unrelated to the clock phase.
    always @(want or slow) begin
        first_raw <= #(slow ? 37 : 3) want[0];
        second_raw <= #(slow ? 37 : 3) want[1];
    end
endmodule

// *** sim/tb_dual_comparator_control.sv ***
`timescale 1ns/1ps
// Self-checking bench: register model in integers against the comparator block.
module tb_dual_comparator_control;
    logic        clock, rst_n, reg_wr, reg_rd, slow, first_raw, second_raw;
    logic        irq_req, wake_req, valid, refp, en, route, insw, act1, act2;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, ctrl, exp;
    logic [1:0]  want, dir, oe;
    logic [2:0]  mode;
    logic [31:0] seed;
    int          errors, cmp_count, n, m;

    dcc_analog_src dcc_analog_src_inst (.slow(slow), .want(want), .first_raw(first_raw),
        .second_raw(second_raw));
    dcc_top dcc_top_inst (.clock(clock), .rst_n(rst_n), .clk_en(en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_raw(first_raw), .second_raw(second_raw), .port_a_direction(dir),
        .irq_req(irq_req), .wake_req(wake_req), .results_valid(valid),
        .comparator_mode_field(mode), .input_switch(insw), .ladder_power_enable(),
        .ladder_range_select(), .ladder_pin_output_enable(), .ladder_tap_select(),
        .ref_on_plus_inputs(refp), .first_active(act1), .second_active(act2),
        .route_to_pins(route),
        .first_invert(), .second_invert(), .pin_drive_oe(oe));

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] want_v);
        cmp_count++;
        if (seen !== want_v) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want_v);
        end
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One-cycle write strobe, released at the edge that takes it, then one idle cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    // One-cycle read; data is compared under a mask in the following cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(reg_rdata & k, e & k);
        @(posedge clock);
    endtask

    // Bounded wait for results valid (0) or interrupt request (1).
    task automatic wait_hi(input int which);
        for (n = 0; n < 1100 && (which ? irq_req : valid) !== 1'b1; n++)
            @(posedge clock);
        if (n == 1100) begin
            chk(8'h00, 8'h01);
            tally_and_finish;
        end
    endtask

    task automatic reset_dut;
        rst_n <= 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
    endtask

    // Main sequence: reset state, every mode, change detection, second reset.
    initial begin
        {rst_n, reg_wr, reg_rd, slow} = 4'h0;
        en = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        want = 2'b00;
        dir = 2'b11;
        errors = 0;
        cmp_count = 0;
        seed = 32'h0C43;
        reset_dut();
        rd(8'h9C, 8'h07, 8'hFF);
        rd(8'h9D, 8'h00, 8'hFF);
        rd(8'h0D, 8'h00, 8'hFF);
        wr(8'h9D, 8'hFF);
        rd(8'h9D, 8'hEF, 8'hFF);
        for (m = 0; m < 8; m++) begin
            seed = lfsr(seed);
            want <= seed[1:0];
            dir <= seed[9:8];
            ctrl = {2'b00, seed[5:4], seed[6], m[2:0]};
            wr(8'h9C, ctrl);
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk({5'h0, mode}, {5'h0, m[2:0]});
            chk({7'h0, insw}, {7'h0, seed[6]});
            chk({7'h0, valid}, 8'h00);
            chk({7'h0, refp}, {7'h0, m == 6});
            chk({6'h0, oe}, (m == 1 || m == 4) ? {6'h0, ~dir} : 8'h00);
            chk({7'h0, route}, {7'h0, m == 1 || m == 4});
            chk({6'h0, act2, act1}, (m == 0 || m == 7) ? 8'h00 : (m == 5 ? 8'h01 : 8'h03));
            if (m != 7)
                wait_hi(0);
            else
                @(posedge clock);
            // Off modes hold both results low, one-comparator mode holds the second low.
            exp[7] = ((m == 0 || m == 5 || m == 7) ? 1'b0 : seed[1]) ^ seed[5];
            exp[6] = ((m == 0 || m == 7) ? 1'b0 : seed[0]) ^ seed[4];
            exp[5:0] = ctrl[5:0];
            rd(8'h9C, exp, 8'hFF);
        end
        want <= 2'b00;
        wr(8'h9C, 8'h02);
        wr(8'h8D, 8'h40);
        wr(8'h0B, 8'hC0);
        wait_hi(0);
        rd(8'h9C, 8'h02, 8'hFF);
        wr(8'h0D, 8'h00);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk({7'h0, irq_req}, 8'h00);
        @(posedge clock);
        slow <= 1'b1;
        want <= 2'b01;
        wait_hi(1);
        wr(8'h0D, 8'h00);
        rd(8'h0D, 8'h40, 8'hFF);
        rd(8'h9C, 8'h42, 8'hFF);
        wr(8'h0D, 8'h00);
        rd(8'h0D, 8'h00, 8'hFF);
        wr(8'h0D, 8'h40);
        rd(8'h0D, 8'h40, 8'hFF);
        wr(8'h0B, 8'h00);
        wr(8'h9C, 8'hD2);
        repeat (2) @(posedge clock);
        rd(8'h9C, 8'h12, 8'hFF);
        rd(8'h00, 8'h00, 8'hFF);
        @(negedge clock);
        chk({6'h0, irq_req, wake_req}, 8'h01);
        @(posedge clock);
        // A write while the clock enable is low must be ignored.
        en <= 1'b0;
        wr(8'h9D, 8'h0F);
        en <= 1'b1;
        rd(8'h9D, 8'hEF, 8'hFF);
        reset_dut();
        rd(8'h9C, 8'h07, 8'hFF);
        rd(8'h9D, 8'h00, 8'hFF);
        tally_and_finish();
    end
endmodule
